// ---- hw/srb_top.sv ----
// Behaviour
// RQ1 - Eight-bit scaler preset from straps; grounded strap is 0, open is 1.
// RQ2 - Scaler of 256 counts, fed by 423,000 pps oscillator via prescaler.
// RQ3 - Range strap picks prescale of 8 or of 64.
// RQ4 - Divide by 8 spans 207-3,110 bps; by 64 spans 26-388 bps.
// RQ5 - Preset needs a zero among its four top bits.
// RQ6 - Rate must match remote terminal within half a percent.
// RQ7 - Factory setting gives 1200 bps; other rates need strap changes.
// RQ8 - Host writes control words to choose mode and parity.
// RQ9 - Control word low nibble holds two's complement of character length.
// RQ10 - Data word low byte is the character, upper byte control and status.
// RQ11 - Upper byte means different things on output and input.
// RQ12 - Control bit 13 selects transmit when 1, receive when 0.
// RQ13 - Control bit 8 enables parity; bit 7 picks odd when set.
// RQ14 - Length counts parity, not start and stop bits.
// RQ15 - At terminal count scaler reloads preset and emits one tick.
`timescale 1ns/10ps
`include "srb_defs.svh"
module srb_top #(
	parameter int OSC_PPS = `SRB_OSC_PPS,
	parameter int PCLK_HZ = `SRB_PCLK_HZ
) (
	// APB slave.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Rate straps.
	input wire logic [7:0] rate_preset_strap,
	input wire srb_pkg::srb_range_e rate_range_strap,
	// Serial shifter control.
	output logic bit_tick,
	output logic ser_tx_mode,
	output logic ser_parity_en,
	output logic ser_parity_odd,
	output logic ser_dtr,
	output logic [3:0] ser_char_bits,
	input wire logic ser_busy,
	// Transmit stream.
	output logic tx_valid,
	input wire logic tx_ready,
	output srb_pkg::srb_char_t tx_char,
	output logic tx_sec_send,
	// Receive stream.
	input wire logic rx_valid,
	output logic rx_ready,
	input wire srb_pkg::srb_char_t rx_char,
	input wire logic rx_parity_err,
	// Line status.
	input wire logic ln_ring,
	input wire logic ln_carrier,
	input wire logic ln_dsr,
	input wire logic ln_sec_recv
);
	import srb_pkg::*;

	// ==========================================================
	// Bus decode.
	wire setup = psel && !penable;
	wire acc = psel && penable;
	wire hit_ctrl = (paddr == `SRB_ADDR_CTRL);
	wire hit_txd = (paddr == `SRB_ADDR_TXD);
	wire hit_rxd = (paddr == `SRB_ADDR_RXD);
	wire hit_rate = (paddr == `SRB_ADDR_RATE);
	wire hit_any = hit_ctrl || hit_txd || hit_rxd || hit_rate;
	wire txf_in_ready;
	wire txd_stall = hit_txd && pwrite && !txf_in_ready;
	wire done = ce && acc && pready;
	wire wr_ctrl = done && pwrite && hit_ctrl;
	wire wr_txd = done && pwrite && hit_txd;
	logic rd_full_ff;
	// RQ11 clear only a character that the read showed.
	wire rd_rxd = done && !pwrite && hit_rxd && rd_full_ff;

	assign pready = ce && !txd_stall;
	assign pslverr = acc && !hit_any;

	// ==========================================================
	// Control word register.
	srb_word_t ctrl_ff;
	srb_word_t nxt_ctrl;

	// RQ9 length decode.
	function automatic logic [3:0] data_bits(input srb_word_t cw);
		logic [4:0] len;
		len = 5'(`SRB_LEN_BASE - {1'b0, cw[`SRB_CW_LEN_MSB:0]});
		data_bits = 4'(len - {4'h0, cw[`SRB_CW_PAR]});
	endfunction

	assign nxt_ctrl = wr_ctrl ? pwdata[15:0] : ctrl_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `SRB_CTRL_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// RQ12 direction select.
	assign ser_tx_mode = ctrl_ff[`SRB_CW_TX];
	// RQ13 parity select.
	assign ser_parity_en = ctrl_ff[`SRB_CW_PAR];
	assign ser_parity_odd = ctrl_ff[`SRB_CW_ODD];
	assign ser_dtr = ctrl_ff[`SRB_CW_DTR];
	// RQ14 parity inside length.
	assign ser_char_bits = data_bits(ctrl_ff);

	// ==========================================================
	// Transmit path.
	wire [8:0] txf_out;
	wire txf_out_valid;

	// RQ10 output word split.
	wire [8:0] txf_in = {pwdata[`SRB_DW_SEC], pwdata[`SRB_DW_CHR_MSB:0]};

	srb_fifo2 #(
		.W(9),
		.DEPTH(2)
	) u_txf (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.in_valid(wr_txd),
		.in_ready(txf_in_ready),
		.in_data(txf_in),
		.out_valid(txf_out_valid),
		.out_ready(tx_ready),
		.out_data(txf_out)
	);

	assign tx_valid = txf_out_valid;
	assign tx_char = txf_out[7:0];
	assign tx_sec_send = txf_out[8];

	// ==========================================================
	// Receive holding register.
	logic rx_full_ff;
	srb_char_t rx_chr_ff;
	logic rx_err_ff;
	wire rx_take = ce && rx_valid && rx_ready;

	assign rx_ready = !rx_full_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_full_ff <= 1'b0;
			rx_chr_ff <= '0;
			rx_err_ff <= 1'b0;
		end else if (rx_take) begin
			rx_full_ff <= 1'b1;
			rx_chr_ff <= rx_char;
			rx_err_ff <= rx_parity_err;
		end else if (rd_rxd) begin
			rx_full_ff <= 1'b0;
		end
	end

	// RQ11 input word status byte.
	wire rdy_bit = ser_tx_mode ? txf_in_ready : rx_full_ff;
	wire [15:0] rx_word = {rdy_bit, ln_sec_recv, ser_busy, ln_dsr,
		ln_carrier, ln_ring, rx_err_ff, 1'b0, rx_chr_ff};

	// ==========================================================
	// Bit-rate chain.
	logic [24:0] osc_acc_ff;
	logic [5:0] pre_cnt_ff;
	logic [7:0] scl_cnt_ff;
	logic scl_first_ff;
	logic tick_ff;
	wire [25:0] osc_sum = {1'b0, osc_acc_ff} + 26'(OSC_PPS);
	wire osc_pulse = (osc_sum >= 26'(PCLK_HZ));
	wire [24:0] nxt_osc_acc = osc_pulse ? 25'(osc_sum - 26'(PCLK_HZ))
		: osc_sum[24:0];

	// RQ3 prescale limit.
	wire [5:0] pre_lim = (rate_range_strap == SRB_DIV64) ?
		`SRB_PRE_B_LIM : `SRB_PRE_A_LIM;
	// RQ4 range from prescale.
	wire pre_tick = osc_pulse && (pre_cnt_ff == pre_lim);
	wire [5:0] nxt_pre_cnt = !osc_pulse ? pre_cnt_ff :
		(pre_tick ? 6'h00 : 6'(pre_cnt_ff + 1'b1));
	// RQ2 scaler terminal count.
	wire scl_term = pre_tick && (scl_cnt_ff == `SRB_SCL_TOP);
	// RQ1 strap preset reload.
	wire [7:0] nxt_scl_cnt = (scl_first_ff || scl_term) ?
		rate_preset_strap :
		(pre_tick ? 8'(scl_cnt_ff + 1'b1) : scl_cnt_ff);
	// RQ5 preset sanity flag.
	wire preset_bad = (rate_preset_strap[7:4] == `SRB_HI_NIB);
	// RQ7 factory rate flag.
	wire rate_factory = (rate_preset_strap == `SRB_FACT_PRESET) &&
		(rate_range_strap == SRB_DIV8);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_acc_ff <= '0;
			pre_cnt_ff <= '0;
			scl_cnt_ff <= '0;
			scl_first_ff <= 1'b1;
			tick_ff <= 1'b0;
		end else if (ce) begin
			osc_acc_ff <= nxt_osc_acc;
			pre_cnt_ff <= nxt_pre_cnt;
			scl_cnt_ff <= nxt_scl_cnt;
			scl_first_ff <= 1'b0;
			// RQ15 reload tick.
			tick_ff <= scl_term && !scl_first_ff;
		end
	end

	assign bit_tick = tick_ff;

	// ==========================================================
	// Read data.
	logic [31:0] prdata_ff;
	wire [31:0] rate_word = {8'h00, scl_cnt_ff, 5'h00, rate_factory,
		preset_bad, rate_range_strap, rate_preset_strap};
	wire [31:0] nxt_prdata = hit_ctrl ? {16'h0000, ctrl_ff} :
		hit_rxd ? {16'h0000, rx_word} :
		hit_rate ? rate_word : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= '0;
			rd_full_ff <= 1'b0;
		end else if (ce && setup && !pwrite) begin
			prdata_ff <= nxt_prdata;
			rd_full_ff <= hit_rxd && rx_full_ff;
		end
	end

	assign prdata = prdata_ff;

	// ==========================================================
	// Checks.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_scaler_reload: assert property ( // RQ15
		ce && scl_term && !scl_first_ff
		|=> bit_tick && scl_cnt_ff == $past(rate_preset_strap))
		else $error("Scaler did not reload or tick.");
	chk_scaler_step: assert property ( // RQ2
		ce && pre_tick && !scl_term && !scl_first_ff
		|=> !bit_tick && scl_cnt_ff == 8'($past(scl_cnt_ff) + 1'b1))
		else $error("Scaler did not advance by one.");
	chk_prescale_div: assert property ( // RQ3
		ce && osc_pulse && pre_cnt_ff == ((rate_range_strap == SRB_DIV64) ?
		`SRB_PRE_B_LIM : `SRB_PRE_A_LIM) |=> pre_cnt_ff == 6'h00)
		else $error("Prescale did not wrap at its limit.");
	chk_prescale_step: assert property ( // RQ3
		ce && osc_pulse && !pre_tick
		|=> pre_cnt_ff == 6'($past(pre_cnt_ff) + 1'b1))
		else $error("Prescale did not advance by one.");
	chk_osc_bound: assert property ( // RQ2
		osc_acc_ff < 25'(PCLK_HZ))
		else $error("Oscillator accumulator out of range.");
	chk_scaler_hold: assert property ( // RQ1
		ce && !pre_tick && !scl_first_ff |=> $stable(scl_cnt_ff))
		else $error("Scaler moved without a prescale tick.");
	chk_mode_bit: assert property ( // RQ12
		wr_ctrl |=> ser_tx_mode == $past(pwdata[`SRB_CW_TX]))
		else $error("Direction not taken from bit 13.");
	chk_parity_sel: assert property ( // RQ13
		wr_ctrl |=> ser_parity_en == $past(pwdata[`SRB_CW_PAR]) &&
		ser_parity_odd == $past(pwdata[`SRB_CW_ODD]))
		else $error("Parity selection wrong.");
	chk_char_len: assert property ( // RQ14
		wr_ctrl && pwdata[3:0] == 4'h8 && pwdata[`SRB_CW_PAR]
		|=> ser_char_bits == 4'h7)
		else $error("Data bits not length less parity.");
	chk_rx_word: assert property ( // RQ10
		rx_take |=> rx_word[7:0] == $past(rx_char) && rx_full_ff)
		else $error("Received character not in low byte.");
	chk_tx_stall: assert property ( // RQ11
		ce && txd_stall && !tx_ready |=> !txf_in_ready)
		else $error("Full buffer changed without a drain.");
	chk_rx_hold: assert property ( // RQ11
		rx_full_ff && !rd_rxd |=> rx_full_ff && $stable(rx_chr_ff))
		else $error("Held character lost.");
	chk_rx_clear: assert property ( // RQ11
		rd_rxd |=> !rx_full_ff && rx_ready)
		else $error("Read did not free the holding register.");
	chk_first_load: assert property ( // RQ1
		ce && scl_first_ff |=> scl_cnt_ff == $past(rate_preset_strap))
		else $error("Scaler not loaded from straps at start.");
	chk_tick_pulse: assert property ( // RQ15
		ce && bit_tick |=> !bit_tick)
		else $error("Bit tick longer than one cycle.");

	cov_bit_tick: cover property (bit_tick);
	cov_tx_stall: cover property (acc && txd_stall ##1 pready);
	cov_rx_read: cover property (rx_take ##[1:20] rd_rxd);
	cov_ctrl_tx: cover property (wr_ctrl && pwdata[`SRB_CW_TX]);
endmodule

// ---- hw/srb_defs.svh ----
`ifndef SRB_DEFS_SVH
`define SRB_DEFS_SVH

// ==========================================================
// Register offsets.
`define SRB_ADDR_CTRL 8'h00
`define SRB_ADDR_TXD 8'h04
`define SRB_ADDR_RXD 8'h08
`define SRB_ADDR_RATE 8'h0C

// ==========================================================
// Control word fields.
`define SRB_CW_LEN_MSB 3
`define SRB_CW_ODD 7
`define SRB_CW_PAR 8
`define SRB_CW_TX 13
`define SRB_CW_DTR 14
`define SRB_CTRL_RST 16'h0000

// ==========================================================
// Data word fields.
`define SRB_DW_CHR_MSB 7
`define SRB_DW_ERR 9
`define SRB_DW_SEC 10
`define SRB_DW_CAR 11
`define SRB_DW_DSR 12
`define SRB_DW_BUSY 13
`define SRB_DW_SRX 14
`define SRB_DW_RDY 15

// ==========================================================
// Rate status fields.
`define SRB_RT_RANGE 8
`define SRB_RT_BAD 9
`define SRB_RT_FACT 10
`define SRB_RT_CNT_LSB 16

// ==========================================================
// Bit-rate chain.
`define SRB_OSC_PPS 423000
`define SRB_PCLK_HZ 25000000
`define SRB_PRE_A_LIM 6'h07
`define SRB_PRE_B_LIM 6'h3F
`define SRB_SCL_TOP 8'hFF
`define SRB_HI_NIB 4'hF
`define SRB_LEN_BASE 5'h10
`define SRB_FACT_PRESET 8'hD4

`endif

// ---- hw/srb_pkg.sv ----
package srb_pkg;
	typedef logic [15:0] srb_word_t;
	typedef logic [7:0] srb_char_t;
	typedef enum logic {
		SRB_DIV8 = 1'b0,
		SRB_DIV64 = 1'b1
	} srb_range_e;
endpackage

// ---- hw/srb_fifo2.sv ----
`timescale 1ns/10ps
`include "srb_defs.svh"
module srb_fifo2 #(
	parameter int W = 9,
	parameter int DEPTH = 2
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Fill side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] mem_ff [DEPTH];
	logic [PW-1:0] wr_ff;
	logic [PW-1:0] rd_ff;
	logic [CW-1:0] cnt_ff;
	wire push = ce && in_valid && in_ready;
	wire pop = ce && out_valid && out_ready;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	assign in_ready = (cnt_ff != CW'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem_ff[rd_ff];

	// ==========================================================
	// Storage and pointers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
		end else begin
			if (push) begin
				mem_ff[wr_ff] <= in_data;
				wr_ff <= ptr_inc(wr_ff);
			end
			if (pop) begin
				rd_ff <= ptr_inc(rd_ff);
			end
			if (push && !pop) begin
				cnt_ff <= CW'(cnt_ff + 1'b1);
			end else if (pop && !push) begin
				cnt_ff <= CW'(cnt_ff - 1'b1);
			end
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_fifo_bound: assert property (cnt_ff <= CW'(DEPTH))
		else $error("Buffer count beyond depth.");
	chk_fifo_order: assert property (push && !pop && cnt_ff == '0
		|=> out_valid && out_data == $past(in_data))
		else $error("Buffer lost or reordered a word.");
	cov_fifo_full: cover property (!in_ready ##1 pop);
endmodule

// ---- test/srb_link_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Far-side shifter model.
module srb_link_model (
	// Clock and pacing.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	// Transmit side.
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_char,
	input wire logic tx_sec_send,
	// Receive side.
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_char,
	output logic rx_parity_err
);
	logic [7:0] cyc_ff = 8'h00;
	logic [7:0] n_ff = 8'h00;
	logic [7:0] nxt_chr;
	logic [8:0] got_q[$];
	assign tx_ready = !slow || (cyc_ff[1:0] == 2'h3);
	assign nxt_chr = n_ff * 8'h35 + 8'h11;
	assign rx_valid = (n_ff < 8'h03);
	assign rx_char = rx_valid ? nxt_chr : ~nxt_chr;
	assign rx_parity_err = rx_valid ? n_ff[0] : ~n_ff[0];
	always @(posedge pclk) begin
		cyc_ff <= cyc_ff + 8'h01;
		if (tx_valid && tx_ready) begin
			got_q.push_back({tx_sec_send, tx_char});
		end
		if (presetn && rx_valid && rx_ready) begin
			n_ff <= n_ff + 8'h01;
		end
	end
endmodule

// ---- test/serial_bit_rate_and_word_format_test.sv ----
`timescale 1ns/10ps
`include "srb_defs.svh"
// ==========================================================
// Bench for the bit-rate and word-format block.
module serial_bit_rate_and_word_format_test;
	import srb_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic slow = 1'b0;
	logic ce = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] rate_preset_strap = `SRB_FACT_PRESET;
	srb_range_e rate_range_strap = SRB_DIV8;
	logic [4:0] ls = 5'h00;
	logic [31:0] prdata;
	logic pready, pslverr, bit_tick, ser_tx_mode, ser_parity_en;
	logic ser_parity_odd, ser_dtr, tx_valid, tx_ready, tx_sec_send;
	logic rx_valid, rx_ready, rx_parity_err;
	logic [3:0] ser_char_bits;
	logic [7:0] tx_char, rx_char;
	int seed = 36;
	int bad_count = 0;
	int check_count = 0;
	srb_top #(.OSC_PPS(25000000), .PCLK_HZ(25000000)) i_srb_top (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rate_preset_strap(rate_preset_strap),
		.rate_range_strap(rate_range_strap), .bit_tick(bit_tick),
		.ser_tx_mode(ser_tx_mode), .ser_parity_en(ser_parity_en),
		.ser_parity_odd(ser_parity_odd), .ser_dtr(ser_dtr),
		.ser_char_bits(ser_char_bits), .ser_busy(ls[3]),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_char(tx_char),
		.tx_sec_send(tx_sec_send), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_char(rx_char),
		.rx_parity_err(rx_parity_err), .ln_ring(ls[0]),
		.ln_carrier(ls[1]), .ln_dsr(ls[2]), .ln_sec_recv(ls[4]));
	srb_link_model i_srb_link_model (
		.pclk(pclk), .presetn(presetn), .slow(slow),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_char(tx_char),
		.tx_sec_send(tx_sec_send), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_char(rx_char),
		.rx_parity_err(rx_parity_err));
	initial begin
		forever #20 pclk = ~pclk;
	end
	function automatic int exp_gap(logic [7:0] p, srb_range_e r);
		return (r == SRB_DIV64 ? 64 : 8) * (256 - p);
	endfunction
	function automatic logic [3:0] exp_bits(logic [15:0] cw);
		return 4'(5'h10 - cw[3:0] - cw[8]);
	endfunction
	function automatic logic rate_near(int c, int bps);
		int err;
		err = `SRB_OSC_PPS - bps * c;
		if (err < 0) err = -err;
		return err * 200 <= bps * c;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 4000);
		if (n >= 4000) bad_count++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_tick(output int c);
		c = 0;
		do begin
			@(posedge pclk);
			c++;
		end while (bit_tick !== 1'b1 && c < 20000);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#(40 * 60000);
		bad_count++;
		close_out;
	end
	initial begin
		logic [31:0] q, d;
		logic e;
		logic [15:0] cw;
		logic [7:0] p;
		logic [8:0] tq[$];
		srb_range_e r;
		int c;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `SRB_ADDR_CTRL, 32'h0, q, e);
		chk(q, 32'h0);
		for (int i = 0; i < 6; i++) begin
			p = 8'($random(seed));
			r = SRB_DIV8;
			// keep a zero in the top nibble.
			if (p[7:4] == `SRB_HI_NIB) p[7] = 1'b0;
			if (i == 0) p = `SRB_FACT_PRESET;
			if (i == 1) p = 8'h00;
			if (i == 2) p = 8'hEF;
			if (i == 4) r = SRB_DIV64;
			if (i == 4) p[7:4] = 4'hE;
			if (i == 5) p = 8'hF8;
			rate_preset_strap <= p;
			rate_range_strap <= r;
			apb(1'b0, `SRB_ADDR_RATE, 32'h0, q, e);
			chk(q[10:0], {p == 8'hD4 && r == SRB_DIV8, &p[7:4], r, p});
			if (i < 5) begin
				repeat (3) wait_tick(c);
				chk(c, exp_gap(p, r));
				if (i == 0) chk(rate_near(c, 1200), 1'b1);
			end
			if (i == 3) begin
				ce <= 1'b0;
				repeat (10) @(posedge pclk);
				ce <= 1'b1;
				wait_tick(c);
				chk(c, exp_gap(p, r));
			end
		end
		$display("test rate done");
		for (int i = 0; i < 20; i++) begin
			cw = 16'($random(seed));
			if (i < 16) cw[3:0] = 4'(i);
			apb(1'b1, `SRB_ADDR_CTRL, {16'h0, cw}, q, e);
			apb(1'b0, `SRB_ADDR_CTRL, 32'h0, q, e);
			chk(q, {16'h0, cw});
			chk({ser_dtr, ser_tx_mode, ser_parity_en, ser_parity_odd},
				{cw[14], cw[13], cw[8], cw[7]});
			chk(ser_char_bits, exp_bits(cw));
		end
		$display("test control done");
		slow <= 1'b1;
		apb(1'b1, `SRB_ADDR_CTRL, 32'h6008, q, e);
		for (int i = 0; i < 4; i++) begin
			d = $random(seed) & 32'h04FF;
			tq.push_back({d[10], d[7:0]});
			apb(1'b1, `SRB_ADDR_TXD, d, q, e);
		end
		c = 0;
		while (i_srb_link_model.got_q.size() < 4 && c < 500) begin
			@(posedge pclk);
			c++;
		end
		for (int i = 0; i < 4; i++) begin
			chk(i_srb_link_model.got_q[i], tq[i]);
		end
		slow <= 1'b0;
		$display("test transmit done");
		ls <= 5'($random(seed));
		apb(1'b1, `SRB_ADDR_CTRL, 32'h4008, q, e);
		for (int k = 0; k < 3; k++) begin
			c = 0;
			do begin
				apb(1'b0, `SRB_ADDR_RXD, 32'h0, q, e);
				c++;
			end while (q[15] !== 1'b1 && c < 50);
			p = 8'(k * 8'h35 + 8'h11);
			chk(q, {16'h0, 1'b1, ls, k[0], 1'b0, p});
		end
		apb(1'b0, `SRB_ADDR_RXD, 32'h0, q, e);
		chk(q[15], 1'b0);
		apb(1'b0, 8'h10, 32'h0, q, e);
		chk(e, 1'b1);
		chk(q, 32'h0);
		$display("test receive done");
		close_out;
	end
endmodule
